/* File: rtl/olc_pkg.sv */
/*
  Shared constants and carrier types for the option byte configuration loader.
  Assumes a single system clock domain and a flash read port on that clock.
*/
package olc_pkg;

  // Location of the option byte in the internal flash array
  localparam int              FLASH_ADDR_W       = 24;
  localparam logic [23:0]     OPTION_BYTE_ADDR   = 24'h00007a;

  // Field positions inside the 8-bit option setting
  localparam int              OPT_SHORT_STAB_BIT = 0;
  localparam int              OPT_RING_LOCK_BIT  = 1;
  localparam int              OPT_PULLUP_LSB     = 4;
  localparam int              PULLUP_COUNT       = 4;

  // Default stabilisation time codes (2^13 and 2^15 main clock periods)
  localparam logic [7:0]      STAB_CODE_2P13     = 8'h00;
  localparam logic [7:0]      STAB_CODE_2P15     = 8'h01;

  // Watchdog clock and mode encodings
  localparam logic            WDT_CLK_RING_DIV8  = 1'b0;
  localparam logic            WDT_CLK_SUBCLOCK   = 1'b1;
  localparam logic            WDT_MODE_NMI       = 1'b0;
  localparam logic            WDT_MODE_RESET     = 1'b1;

  // Reset values of the software controlled bits and of the fetched option byte
  localparam logic            RING_STOP_RESET    = 1'b0;
  localparam logic            WDT_STOP_RESET     = 1'b0;
  localparam logic            WDT_CLK_RESET      = WDT_CLK_RING_DIV8;
  localparam logic            WDT_MODE_RESET_VAL = WDT_MODE_RESET;
  localparam logic [7:0]      OPTION_RESET       = 8'h00;

  // Captured option settings
  typedef struct packed {
    logic [PULLUP_COUNT-1:0] port_pullup_option;
    logic                    ringosc_stop_lock;
    logic                    short_stab_option;
  } olc_opt_t;

  // Watchdog mode register fields as written by software
  typedef struct packed {
    logic watchdog_count_stop_bit;
    logic clk_sel;
    logic mode_sel;
  } olc_wdt_cfg_t;

  localparam olc_wdt_cfg_t WDT_CFG_RESET = '{
    watchdog_count_stop_bit: WDT_STOP_RESET,
    clk_sel:                 WDT_CLK_RESET,
    mode_sel:                WDT_MODE_RESET_VAL
  };

endpackage

/* File: rtl/olc_opt_fetch.sv */
/*
  One-shot reader of the option byte from the internal flash array.
  Assumes the flash read port answers on the same clock with a valid strobe.
*/
`timescale 1ns/1ps
module olc_opt_fetch
  import olc_pkg::*;
(
  // Clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    resetn_i,
  // Flash read port
  output logic                         flash_rd_o,
  output logic [olc_pkg::FLASH_ADDR_W-1:0] flash_addr_o,
  input  wire logic [7:0]              flash_rdata_i,
  input  wire logic                    flash_rvalid_i,
  // Result
  output logic [7:0]                   opt_byte_o,
  output logic                         done_o
);
  import olc_pkg::*;

  typedef enum logic [1:0] {ISSUE, WAIT, DONE} olc_fetch_state_t;

  olc_fetch_state_t state;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state      <= ISSUE;
      flash_rd_o <= 1'b0;
      opt_byte_o <= OPTION_RESET;
      done_o     <= 1'b0;
    end else begin
      flash_rd_o <= 1'b0;
      unique case (state)
        ISSUE: begin
          flash_rd_o <= 1'b1;
          state      <= WAIT;
        end
        WAIT: begin
          if (flash_rvalid_i) begin
            opt_byte_o <= flash_rdata_i;
            done_o     <= 1'b1;
            state      <= DONE;
          end
        end
        DONE: begin
          // Held until the next reset
          state <= DONE;
        end
      endcase
    end
  end

  assign flash_addr_o = OPTION_BYTE_ADDR;

endmodule

/* File: rtl/olc_loader.sv */
/*
  Option byte / mask option configuration loader and the option gated
  ring oscillator stop bit and secondary watchdog mode bits.
  Assumes the stabilisation counter, the watchdog and the port logic are held
  in reset until sys_release_o rises, and that all inputs share core_clk_i.
*/
`timescale 1ns/1ps
module olc_loader
  import olc_pkg::*;
#(
  parameter bit         IS_FLASH       = 1'b1,
  parameter logic [7:0] MASK_OPTIONS   = 8'h00,
  parameter int         PULLUP_PINS    = PULLUP_COUNT
)
(
  // Clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            resetn_i,
  // Flash read port
  output logic                                 flash_rd_o,
  output logic [olc_pkg::FLASH_ADDR_W-1:0]     flash_addr_o,
  input  wire logic [7:0]                      flash_rdata_i,
  input  wire logic                            flash_rvalid_i,
  // Release of the logic that depends on the options
  output logic                                 sys_release_o,
  // Captured options
  output olc_pkg::olc_opt_t                    options_o,
  output logic [7:0]                           stab_time_init_o,
  output logic [PULLUP_PINS-1:0]               pullup_enable_o,
  // Ring oscillator stop bit
  input  wire logic                            ringosc_stop_request_wr_i,
  input  wire logic                            ringosc_stop_request_i,
  output logic                                 ringosc_stop_o,
  // Watchdog mode register
  input  wire logic                            watchdog_mode_reg_wr_i,
  input  wire olc_pkg::olc_wdt_cfg_t           watchdog_mode_reg_i,
  output olc_pkg::olc_wdt_cfg_t                watchdog_cfg_o
);
  import olc_pkg::*;

  // Elaboration checks; the pull-up field is fixed inside the option byte
  if (PULLUP_PINS != PULLUP_COUNT) begin : g_bad_pins
    $error("PULLUP_PINS must equal the option field width");
  end
  if (OPT_PULLUP_LSB + PULLUP_COUNT > 8) begin : g_bad_field
    $error("Pull-up field runs past the option byte");
  end

  logic [7:0] fetched_byte;
  logic       fetch_done;
  logic       flash_rd;
  logic [FLASH_ADDR_W-1:0] flash_addr;
  logic       loaded;
  logic [7:0] raw_opt;
  olc_opt_t   next_opt;
  olc_opt_t   opt;
  logic       ring_stop_bit;
  olc_wdt_cfg_t wdt_reg;
  olc_wdt_cfg_t next_wdt_eff;
  logic       read_taken;
  logic       fetch_rvalid;
  logic [7:0] next_stab_code;

  // Flash parts fetch the option byte; mask parts use fixed options
  generate
    if (IS_FLASH) begin : g_flash
      olc_opt_fetch u_fetch (
        .core_clk_i     (core_clk_i),
        .resetn_i       (resetn_i),
        .flash_rd_o     (flash_rd),
        .flash_addr_o   (flash_addr),
        .flash_rdata_i  (flash_rdata_i),
        .flash_rvalid_i (fetch_rvalid),
        .opt_byte_o     (fetched_byte),
        .done_o         (fetch_done)
      );
    end else begin : g_mask
      assign flash_rd     = 1'b0;
      assign flash_addr   = '0;
      assign fetched_byte = MASK_OPTIONS;
      assign fetch_done   = 1'b1;
    end
  endgenerate

  assign raw_opt = fetched_byte;

  always_comb begin
    next_opt.short_stab_option = raw_opt[OPT_SHORT_STAB_BIT];
    next_opt.ringosc_stop_lock = raw_opt[OPT_RING_LOCK_BIT];
    // Flash parts carry no pull-up field at all
    if (IS_FLASH) begin
      next_opt.port_pullup_option = '0;
    end else begin
      next_opt.port_pullup_option = raw_opt[OPT_PULLUP_LSB +: PULLUP_COUNT];
    end
  end

  // Flash port outputs registered to keep them glitch free
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_rd_o   <= 1'b0;
      flash_addr_o <= '0;
    end else begin
      flash_rd_o   <= flash_rd;
      flash_addr_o <= flash_addr;
    end
  end

  // Request is registered once more, so an answer before or in the cycle the request is on the port is refused
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      read_taken <= 1'b0;
    end else if (flash_rd_o) begin
      read_taken <= 1'b1;
    end
  end

  assign fetch_rvalid = flash_rvalid_i && read_taken;

  // Capture once, then freeze; dependents stay held until then
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loaded <= 1'b0;
      opt    <= '0;
    end else if (!loaded && fetch_done) begin
      loaded <= 1'b1;
      opt    <= next_opt;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sys_release_o <= 1'b0;
    end else begin
      sys_release_o <= loaded;
    end
  end

  // Default stabilisation code from the captured option
  always_comb begin
    if (opt.short_stab_option) begin
      next_stab_code = STAB_CODE_2P15;
    end else begin
      next_stab_code = STAB_CODE_2P13;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      options_o        <= '0;
      stab_time_init_o <= STAB_CODE_2P13;
    end else begin
      options_o        <= opt;
      stab_time_init_o <= next_stab_code;
    end
  end

  // One pull-up enable per port pin
  generate
    for (genvar i = 0; i < PULLUP_PINS; i++) begin : g_pullup
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pullup_enable_o[i] <= 1'b0;
        end else begin
          pullup_enable_o[i] <= opt.port_pullup_option[i];
        end
      end
    end
  endgenerate

  // Stop bit writes are dropped while locked, so the oscillator keeps running
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ring_stop_bit <= RING_STOP_RESET;
    end else if (loaded && ringosc_stop_request_wr_i && !opt.ringosc_stop_lock) begin
      ring_stop_bit <= ringosc_stop_request_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ringosc_stop_o <= RING_STOP_RESET;
    end else begin
      ringosc_stop_o <= ring_stop_bit && !opt.ringosc_stop_lock;
    end
  end

  // Watchdog mode register keeps what software wrote
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_reg <= WDT_CFG_RESET;
    end else if (loaded && watchdog_mode_reg_wr_i) begin
      wdt_reg <= watchdog_mode_reg_i;
    end
  end

  // Lock overrides the written fields rather than blocking the write
  always_comb begin
    next_wdt_eff = wdt_reg;
    if (opt.ringosc_stop_lock) begin
      next_wdt_eff.watchdog_count_stop_bit = 1'b0;
      next_wdt_eff.clk_sel                 = WDT_CLK_RING_DIV8;
      next_wdt_eff.mode_sel                = WDT_MODE_RESET;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      watchdog_cfg_o <= WDT_CFG_RESET;
    end else begin
      watchdog_cfg_o <= next_wdt_eff;
    end
  end

endmodule

/* File: bench/olc_loader_assertions.sv */
/*
  Port assertions for the option byte loader.
  Assumes binding into olc_loader: one clock, asynchronous low reset.
*/
`timescale 1ns/1ps
module olc_loader_assertions
  import olc_pkg::*;
#(
  parameter int PULLUP_PINS = PULLUP_COUNT
)
(
  // Clock and reset
  input wire logic                    core_clk_i,
  input wire logic                    resetn_i,
  // Watched ports
  input wire logic                    flash_rd_o,
  input wire logic [23:0]             flash_addr_o,
  input wire logic                    sys_release_o,
  input wire olc_pkg::olc_opt_t       options_o,
  input wire logic [7:0]              stab_time_init_o,
  input wire logic [PULLUP_PINS-1:0]  pullup_enable_o,
  input wire logic                    ringosc_stop_request_wr_i,
  input wire logic                    ringosc_stop_request_i,
  input wire logic                    ringosc_stop_o,
  input wire logic                    watchdog_mode_reg_wr_i,
  input wire olc_pkg::olc_wdt_cfg_t   watchdog_mode_reg_i,
  input wire olc_pkg::olc_wdt_cfg_t   watchdog_cfg_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_read_addr: assert property (flash_rd_o |-> flash_addr_o == OPTION_BYTE_ADDR)
    else $error("option read at wrong address");
  a_stab_code: assert property (sys_release_o |-> stab_time_init_o ==
    (options_o.short_stab_option ? STAB_CODE_2P15 : STAB_CODE_2P13)) else $error("stab code wrong");
  a_pullup_map: assert property (sys_release_o |->
    pullup_enable_o == PULLUP_PINS'(options_o.port_pullup_option)) else $error("pullup mismatch");
  a_opts_hold: assert property (sys_release_o && $past(sys_release_o) |-> $stable(options_o))
    else $error("options changed after capture");
  a_lock_no_stop: assert property (sys_release_o && options_o.ringosc_stop_lock |-> !ringosc_stop_o)
    else $error("oscillator stopped while locked");
  a_lock_wdt_fix: assert property (sys_release_o && options_o.ringosc_stop_lock |->
    watchdog_cfg_o == WDT_CFG_RESET) else $error("watchdog not forced");
  a_stop_write: assert property (sys_release_o && ringosc_stop_request_wr_i && !options_o.ringosc_stop_lock
    |-> ##2 ringosc_stop_o == $past(ringosc_stop_request_i, 2)) else $error("stop write lost");
  a_wdt_write: assert property (sys_release_o && watchdog_mode_reg_wr_i && !options_o.ringosc_stop_lock
    |-> ##2 watchdog_cfg_o == $past(watchdog_mode_reg_i, 2)) else $error("watchdog write lost");
endmodule

bind olc_loader olc_loader_assertions #(.PULLUP_PINS(PULLUP_PINS)) chk_inst (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o),
  .sys_release_o(sys_release_o), .options_o(options_o), .stab_time_init_o(stab_time_init_o),
  .pullup_enable_o(pullup_enable_o), .ringosc_stop_request_wr_i(ringosc_stop_request_wr_i),
  .ringosc_stop_request_i(ringosc_stop_request_i), .ringosc_stop_o(ringosc_stop_o),
  .watchdog_mode_reg_wr_i(watchdog_mode_reg_wr_i), .watchdog_mode_reg_i(watchdog_mode_reg_i),
  .watchdog_cfg_o(watchdog_cfg_o));

/* File: bench/tb_top.sv */
/*
  Self-checking bench for the option loader, flash and mask builds.
  Assumes olc_pkg and olc_loader are compiled before it.
*/
`timescale 1ns/1ps
module tb_top;
  import olc_pkg::*;
  logic         core_clk_i = 1'b0;
  logic         resetn_i   = 1'b0;
  logic         rvalid     = 1'b0;
  logic         swr        = 1'b0;
  logic         sreq       = 1'b0;
  logic         wwr        = 1'b0;
  logic [7:0]   rdata      = 8'h00;
  olc_wdt_cfg_t wcfg       = WDT_CFG_RESET;
  logic         rd, rel, stop;
  logic [23:0]  addr;
  logic [7:0]   stab;
  logic [3:0]   pu;
  olc_opt_t     opts;
  olc_wdt_cfg_t cfg;
  logic         mrd, mrel, mstop;
  logic [7:0]   mstab;
  logic [3:0]   mpu;
  olc_opt_t     mopts;
  olc_wdt_cfg_t mcfg;
  // Mask build: short stabilisation, unlocked, alternating pull-ups
  localparam logic [7:0] MASK_OPT = 8'h51;
  int           num_errors = 0;
  int           num_checks = 0;

  always #10 core_clk_i = ~core_clk_i;

  olc_loader olc_loader_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .flash_rd_o(rd), .flash_addr_o(addr),
    .flash_rdata_i(rdata), .flash_rvalid_i(rvalid), .sys_release_o(rel), .options_o(opts),
    .stab_time_init_o(stab), .pullup_enable_o(pu), .ringosc_stop_request_wr_i(swr),
    .ringosc_stop_request_i(sreq), .ringosc_stop_o(stop), .watchdog_mode_reg_wr_i(wwr),
    .watchdog_mode_reg_i(wcfg), .watchdog_cfg_o(cfg));

  olc_loader #(
    .IS_FLASH(1'b0), .MASK_OPTIONS(MASK_OPT)
  ) olc_loader_mask_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .flash_rd_o(mrd), .flash_addr_o(),
    .flash_rdata_i(rdata), .flash_rvalid_i(rvalid), .sys_release_o(mrel), .options_o(mopts),
    .stab_time_init_o(mstab), .pullup_enable_o(mpu), .ringosc_stop_request_wr_i(swr),
    .ringosc_stop_request_i(sreq), .ringosc_stop_o(mstop), .watchdog_mode_reg_wr_i(wwr),
    .watchdog_mode_reg_i(wcfg), .watchdog_cfg_o(mcfg));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reset, offer an early answer, answer the read, then send a stale late answer
  task automatic boot(input logic [7:0] opt);
    int n;
    resetn_i = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    check("read_req", 24'h1, 24'(rd));
    check("read_addr", OPTION_BYTE_ADDR, addr);
    // Answer on the edge that takes the request must be refused
    rvalid = 1'b1;
    rdata  = ~opt;
    @(posedge core_clk_i);
    #1 rdata = opt;
    check("read_pulse", 24'h0, 24'(rd));
    @(posedge core_clk_i);
    #1 rvalid = 1'b0;
    rdata = ~opt;
    n = 0;
    while (rel !== 1'b1) begin
      @(posedge core_clk_i);
      #1 n++;
      if (n > 20) begin
        check("release", 24'h1, 24'(rel));
        complete_run();
      end
    end
    rvalid = 1'b1;
    @(posedge core_clk_i);
    #1 rvalid = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    check("options", 24'({4'h0, opt[1], opt[0]}), 24'(opts));
    check("stab_code", 24'(opt[0] ? STAB_CODE_2P15 : STAB_CODE_2P13), 24'(stab));
    check("pullups", 24'h0, 24'(pu));
    check("mask_release", 24'h1, 24'(mrel));
    check("mask_options", 24'({MASK_OPT[7:4], MASK_OPT[1], MASK_OPT[0]}), 24'(mopts));
    check("mask_stab", 24'(MASK_OPT[0] ? STAB_CODE_2P15 : STAB_CODE_2P13), 24'(mstab));
    check("mask_pullups", 24'(MASK_OPT[7:4]), 24'(mpu));
    check("mask_read", 24'h0, 24'(mrd));
    $display("boot with option %h done", opt);
  endtask

  // Both strobes on one edge; outputs settle two edges later
  task automatic sw_write(input logic [2:0] w, input logic lock);
    sreq = w[0];
    wcfg = w;
    swr  = 1'b1;
    wwr  = 1'b1;
    @(posedge core_clk_i);
    #1 swr = 1'b0;
    wwr  = 1'b0;
    sreq = ~w[0];
    wcfg = ~w;
    repeat (2) @(posedge core_clk_i);
    #1;
    check("osc_stop", 24'(w[0] & ~lock), 24'(stop));
    check("wdt_cfg", lock ? 24'(WDT_CFG_RESET) : 24'(w), 24'(cfg));
    check("mask_osc_stop", 24'(w[0] & ~MASK_OPT[1]), 24'(mstop));
    check("mask_wdt_cfg", MASK_OPT[1] ? 24'(WDT_CFG_RESET) : 24'(w), 24'(mcfg));
  endtask

  initial begin
    boot(8'hf1);
    for (int v = 0; v < 8; v++)
      sw_write(3'(v), 1'b0);
    $display("unlocked write sweep done");
    boot(8'h52);
    for (int v = 7; v >= 0; v--)
      sw_write(3'(v), 1'b1);
    $display("locked write sweep done");
    boot(8'h03);
    sw_write(3'h7, 1'b1);
    $display("locked single write done");
    complete_run();
  end
endmodule
